// ==== core/ltes_top.sv ====
// status register bank: lane 2/3 training requests, adaptive eq results
// assumes a byte register port from the i2c/snoop front end on clk_i,
// and an equalizer engine on the same clock giving pulses and results
`timescale 1ns/1ns
`default_nettype none
`include "ltes_cfg.svh"
module ltes_top
    import ltes_pkg::*;
(
    input wire logic clk_i, // core clock 100 MHz
    input wire logic sys_rst_i, // sync reset, high
    input wire logic ce_i, // clock enable, freezes all state
    input wire logic [7:0] reg_addr_i, // register offset
    input wire logic [7:0] reg_wdata_i, // host write data
    input wire logic reg_wr_i, // host write strobe
    input wire logic reg_rd_i, // host read strobe
    output logic [7:0] reg_rdata_o, // registered read data
    input wire logic snoop_vld_i, // snooped ddc byte to offset 42h
    input wire logic [7:0] snoop_data_i, // snooped byte value
    input wire logic [3:0] max_tx_ffe_level_i, // max ffe level code
    input wire logic adaptive_eq_enable_i, // adaptive eq enabled
    input wire logic link_training_i, // link training in progress
    input wire logic forced_eq_run_enable_i, // forced run mode
    input wire logic forced_eq_run_i, // force bit, hw clears it
    input wire logic full_aeq_mode_i, // full adaptive mode
    input wire logic [2:0] eq_override_offset_i, // override offset low bits; {sign,mag} is a 4-bit two's complement value
    input wire logic eq_override_sign_i, // 1 = negative offset
    input wire logic run_start_i, // pulse: adaptive run starts
    input wire logic run_done_i, // pulse: adaptive run finished
    input wire logic [3:0] run_eq_code_i, // raw eq code at run_done_i
    input wire logic [2:0] run_swing_i, // swing range at run_done_i
    input wire logic [3:0] run_eye_i, // eye quality at run_done_i
    input wire logic hit_i, // pulse: one equalizer hit
    input wire logic settle_expired_i, // pulse: dac wait timer expired
    output logic [1:0] lane2_ffe_level_o, // lane 2 ffe level
    output logic [1:0] lane3_ffe_level_o, // lane 3 ffe level
    output logic eq_done_valid_o // done flag is meaningful
);
    ltes_nib_t lane2_pattern_request_r, lane2_pattern_request_nxt;
    ltes_nib_t lane3_pattern_request_r, lane3_pattern_request_nxt;
    ltes_eq_state_t state_r, state_nxt;
    logic eq_done_flag_r, eq_done_flag_nxt;
    logic [`LTES_HC_W-1:0] hit_cnt_r, hit_cnt_nxt;
    logic eq_hit_counter_overflow_r, eq_hit_counter_overflow_nxt;
    logic settle_timer_done_r, settle_timer_done_nxt;
    ltes_nib_t optimal_eq_code_r, optimal_eq_code_nxt;
    logic [2:0] output_swing_range_r, output_swing_range_nxt;
    ltes_nib_t eye_quality_r, eye_quality_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic req_upd;
    logic [7:0] req_byte;
    logic lane_adv [`LTES_NUM_LANES];
    logic any_clr;
    logic [1:0] lvl [`LTES_NUM_LANES];

    // signed offset applied to the raw code, wrapping in 4 bits
    function automatic ltes_nib_t apply_offset(input ltes_nib_t code,
        input logic [2:0] mag, input logic neg);
        ltes_nib_t m;
        m = {1'b0, mag};
        if (neg) begin
            apply_offset = code - (4'h8 - m);
        end else begin
            apply_offset = code + m;
        end
    endfunction : apply_offset

    // host write wins over a snoop in the same cycle
    always_comb begin
        req_upd = 1'b0;
        req_byte = snoop_data_i;
        if (reg_wr_i && (reg_addr_i == `LTES_OFS_LANE23)) begin
            req_upd = 1'b1;
            req_byte = reg_wdata_i;
        end else if (snoop_vld_i) begin
            req_upd = 1'b1;
        end
    end

    always_comb begin
        lane2_pattern_request_nxt = lane2_pattern_request_r;
        lane3_pattern_request_nxt = lane3_pattern_request_r;
        if (req_upd) begin
            lane3_pattern_request_nxt = req_byte[7:4]; // [RL1] [RL2]
            lane2_pattern_request_nxt = req_byte[3:0]; // [RL1] [RL2]
        end
        lane_adv[0] = req_upd && (req_byte[3:0] == `LTES_REQ_ADVANCE); // [RL3]
        lane_adv[1] = req_upd && (req_byte[7:4] == `LTES_REQ_ADVANCE); // [RL3]
        any_clr = req_upd && ((req_byte[3:0] == `LTES_REQ_CLEAR) ||
            (req_byte[7:4] == `LTES_REQ_CLEAR)); // [RL4]
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lane2_pattern_request_r <= 4'(`LTES_RST_LANE23); // [RL16]
            lane3_pattern_request_r <= 4'(`LTES_RST_LANE23 >> 4); // [RL16]
        end else if (ce_i) begin
            lane2_pattern_request_r <= lane2_pattern_request_nxt;
            lane3_pattern_request_r <= lane3_pattern_request_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LTES_NUM_LANES; g++) begin : g_lane
            ltes_ffe_tracker u_trk (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .adv_i(lane_adv[g]),
                .clr_i(any_clr),
                .max_level_i(max_tx_ffe_level_i),
                .level_o(lvl[g])
            );
        end
    endgenerate

    assign lane2_ffe_level_o = lvl[0];
    assign lane3_ffe_level_o = lvl[1];

    // equalizer run tracking and result capture
    always_comb begin
        state_nxt = state_r;
        eq_done_flag_nxt = eq_done_flag_r;
        optimal_eq_code_nxt = optimal_eq_code_r;
        output_swing_range_nxt = output_swing_range_r;
        eye_quality_nxt = eye_quality_r;
        case (state_r)
            LTES_IDLE: begin
                if (run_start_i) begin
                    state_nxt = LTES_RUN;
                    eq_done_flag_nxt = 1'b0; // [RL17] [RL5]
                end
            end
            LTES_RUN: begin
                if (run_done_i) begin
                    state_nxt = LTES_IDLE;
                    eq_done_flag_nxt = 1'b1; // [RL17] [RL5]
                    if (full_aeq_mode_i) begin
                        optimal_eq_code_nxt = apply_offset(run_eq_code_i,
                            eq_override_offset_i,
                            eq_override_sign_i); // [RL9] [RL10] [RL15]
                    end else begin
                        optimal_eq_code_nxt = run_eq_code_i; // [RL9]
                    end
                    output_swing_range_nxt = run_swing_i; // [RL11]
                    eye_quality_nxt = run_eye_i; // [RL12]
                end
            end
            default: begin
                state_nxt = LTES_IDLE;
                eq_done_flag_nxt = 1'b1;
            end
        endcase
    end

    // sticky flags have no clear path; only reset drops them
    always_comb begin
        hit_cnt_nxt = hit_cnt_r;
        eq_hit_counter_overflow_nxt = eq_hit_counter_overflow_r;
        settle_timer_done_nxt = settle_timer_done_r;
        if (run_start_i && (state_r == LTES_IDLE)) begin
            hit_cnt_nxt = '0;
        end else if (hit_i) begin
            hit_cnt_nxt = hit_cnt_r + 13'h1; // [RL7]
        end
        // a wrapping hit is not lost to a run start in the same cycle
        if (hit_i && (&hit_cnt_r)) begin
            eq_hit_counter_overflow_nxt = 1'b1; // [RL7]
        end
        if (settle_expired_i) begin
            settle_timer_done_nxt = 1'b1; // [RL8]
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= LTES_IDLE;
            eq_done_flag_r <= 1'b1; // [RL5]
            optimal_eq_code_r <= 4'h0;
            output_swing_range_r <= 3'h0;
            eye_quality_r <= 4'h0;
            hit_cnt_r <= '0;
            eq_hit_counter_overflow_r <= 1'b0;
            settle_timer_done_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            eq_done_flag_r <= eq_done_flag_nxt;
            optimal_eq_code_r <= optimal_eq_code_nxt;
            output_swing_range_r <= output_swing_range_nxt;
            eye_quality_r <= eye_quality_nxt;
            hit_cnt_r <= hit_cnt_nxt;
            eq_hit_counter_overflow_r <= eq_hit_counter_overflow_nxt;
            settle_timer_done_r <= settle_timer_done_nxt;
        end
    end

    // done flag only trustworthy in training or after hw dropped force
    assign eq_done_valid_o = (link_training_i && adaptive_eq_enable_i) ||
        (forced_eq_run_enable_i && !forced_eq_run_i); // [RL6]

    // readback; unmapped offsets and reserved bits read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LTES_OFS_LANE23: begin
                    rdata_nxt = {lane3_pattern_request_r,
                        lane2_pattern_request_r}; // [RL1] [RL2]
                end
                `LTES_OFS_RESULT: begin
                    rdata_nxt = 8'h00;
                    rdata_nxt[`LTES_BIT_DONE] = eq_done_flag_r; // [RL5]
                    rdata_nxt[`LTES_BIT_OVF] =
                        eq_hit_counter_overflow_r; // [RL7]
                    rdata_nxt[`LTES_BIT_SETTLE] = settle_timer_done_r; // [RL8]
                    rdata_nxt[3:0] = optimal_eq_code_r; // [RL9]
                end
                `LTES_OFS_EYE: begin
                    rdata_nxt = {1'b0, output_swing_range_r,
                        eye_quality_r}; // [RL11] [RL12]
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 8'h00;
        end else if (ce_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
endmodule : ltes_top
`default_nettype wire

// ==== core/ltes_cfg.svh ====
// constants for the link training / equalizer status register bank
// assumes the byte register port and the equalizer core share one clock
// Behaviour
// RL1 - lane 3 request in bits 7-4, lane 2 request in bits 3-0 at 42h
// RL2 - request fields read back last snooped or host-written value
// RL3 - request Eh advances that lane's ffe level, saturating at maximum
// RL4 - request Fh returns every lane's ffe level to zero
// RL5 - done flag bit 7 is 0 while running, 1 when done; resets to 1
// RL6 - done flag valid only in training with eq enabled or after force
// RL7 - 13-bit hit counter; sticky overflow status in bit 6
// RL8 - settle-done flag bit 4 set when the dac wait timer expires
// RL9 - optimal eq code from the run shown in bits 3-0 at 50h
// RL10 - reported optimal code already includes the signed override offset
// RL11 - output swing range of last run shown in bits 6-4 at 51h
// RL12 - eye quality of last run, 4 bits in 3-0, maximum 15
// RL13 - processor raises enable pin only after supply rails are stable
// RL14 - max ffe level code 0h..3h allows levels zero up to that code
// RL15 - override offset 3 bits plus sign, used only in full adaptive mode
// RL16 - after reset max_tx_ffe_level are zero and request fields read zero; reset here zeroes the lane ffe levels, max_tx_ffe_level_i is an input
// RL17 - done flag clears when a run starts and sets when it finishes
`ifndef LTES_CFG_SVH
`define LTES_CFG_SVH
`define LTES_OFS_LANE23 8'h42
`define LTES_OFS_RESULT 8'h50
`define LTES_OFS_EYE 8'h51
`define LTES_RST_LANE23 8'h00
`define LTES_RST_RESULT 8'h80
`define LTES_RST_EYE 8'h00
`define LTES_REQ_ADVANCE 4'he
`define LTES_REQ_CLEAR 4'hf
`define LTES_BIT_DONE 7
`define LTES_BIT_OVF 6
`define LTES_BIT_SETTLE 4
`define LTES_HC_W 13
`define LTES_NUM_LANES 2
`endif

// ==== core/ltes_pkg.sv ====
// types for the link training / equalizer status register bank
// assumes ltes_cfg.svh is included by users alongside
package ltes_pkg;
    typedef logic [1:0] ltes_level_t;
    typedef logic [3:0] ltes_nib_t;
    typedef enum logic [1:0] {
        LTES_IDLE,
        LTES_RUN
    } ltes_eq_state_t;
endpackage : ltes_pkg

// ==== core/ltes_ffe_tracker.sv ====
// one lane's transmit ffe level tracker
// assumes request strobes are single-cycle pulses on clk_i
`timescale 1ns/1ns
`default_nettype none
`include "ltes_cfg.svh"
module ltes_ffe_tracker
    import ltes_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic sys_rst_i, // sync reset, high
    input wire logic ce_i, // clock enable
    input wire logic adv_i, // advance pulse for this lane
    input wire logic clr_i, // clear pulse, any lane
    input wire logic [3:0] max_level_i, // max supported level code
    output logic [1:0] level_o // current ffe level
);
    ltes_level_t level_r, level_nxt;
    logic [3:0] cap;

    always_comb begin
        // codes above 3h have no meaning; clamp to the top level
        cap = (max_level_i > 4'h3) ? 4'h3 : max_level_i; // [RL14]
        level_nxt = level_r;
        if (clr_i) begin
            level_nxt = 2'h0; // [RL4]
        end else if (adv_i && ({2'h0, level_r} < cap)) begin
            level_nxt = level_r + 2'h1; // [RL3]
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            level_r <= 2'h0; // [RL16]
        end else if (ce_i) begin
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;
endmodule : ltes_ffe_tracker
`default_nettype wire

// ==== verif/ltes_monitor.sv ====
// assertion checker for ltes_top, sees only its ports
// assumes a bind from the bench top; one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module ltes_monitor (
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic ce_i, // enable
    input wire logic [7:0] reg_addr_i, // offset
    input wire logic [7:0] reg_wdata_i, // wdata
    input wire logic reg_wr_i, // write
    input wire logic reg_rd_i, // read
    input wire logic [7:0] reg_rdata_o, // rdata
    input wire logic snoop_vld_i, // snoop
    input wire logic [7:0] snoop_data_i, // snoop byte
    input wire logic [3:0] max_tx_ffe_level_i, // max code
    input wire logic adaptive_eq_enable_i, // eq on
    input wire logic link_training_i, // training
    input wire logic forced_eq_run_enable_i, // forced mode
    input wire logic forced_eq_run_i, // force bit
    input wire logic full_aeq_mode_i, // full mode
    input wire logic [2:0] eq_override_offset_i, // offset
    input wire logic eq_override_sign_i, // sign
    input wire logic run_start_i, // start
    input wire logic run_done_i, // done
    input wire logic [3:0] run_eq_code_i, // raw code
    input wire logic [2:0] run_swing_i, // swing
    input wire logic [3:0] run_eye_i, // eye
    input wire logic [1:0] lane2_ffe_level_o, // lane 2
    input wire logic [1:0] lane3_ffe_level_o, // lane 3
    input wire logic eq_done_valid_o // valid
);
    logic wr42, sn, clr, rd50, rd51, run_r, run_nxt;
    logic [7:0] b;
    logic [1:0] cap;
    logic [10:0] res_r, res_nxt;
    always_comb begin
        wr42 = ce_i && reg_wr_i && reg_addr_i == 8'h42;
        sn = ce_i && snoop_vld_i && !wr42;
        b = wr42 ? reg_wdata_i : snoop_data_i;
        clr = (wr42 || sn) && (b[7:4] == 4'hf || b[3:0] == 4'hf);
        cap = max_tx_ffe_level_i > 4'h3 ? 2'h3 : max_tx_ffe_level_i[1:0];
        rd50 = ce_i && reg_rd_i && reg_addr_i == 8'h50;
        rd51 = ce_i && reg_rd_i && reg_addr_i == 8'h51;
        run_nxt = run_r;
        res_nxt = res_r;
        if (ce_i && run_start_i && !run_r) run_nxt = 1'b1;
        else if (ce_i && run_done_i) run_nxt = 1'b0;
        // signed offset is {sign,mag} added modulo 16
        if (ce_i && run_done_i && run_r) res_nxt = {run_swing_i, run_eye_i,
            full_aeq_mode_i ? run_eq_code_i
            + {eq_override_sign_i, eq_override_offset_i} : run_eq_code_i};
    end
    always_ff @(posedge clk_i) begin
        run_r <= sys_rst_i ? 1'b0 : run_nxt;
        res_r <= sys_rst_i ? 11'h000 : res_nxt;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_start; ce_i && run_start_i && !run_r; endsequence
    sequence s_end; ce_i && run_done_i && run_r; endsequence
    sequence s_wr_rd;
        wr42 ##1 (ce_i && reg_rd_i && reg_addr_i == 8'h42 && !reg_wr_i
            && !snoop_vld_i);
    endsequence
    a_level_clear: assert property (clr |=> lane2_ffe_level_o == 2'h0
        && lane3_ffe_level_o == 2'h0) else $error("levels not cleared");
    a_lane3_adv: assert property ((wr42 || sn) && !clr && b[7:4] == 4'he
        && lane3_ffe_level_o < cap |=> lane3_ffe_level_o
        == $past(lane3_ffe_level_o) + 2'h1) else $error("lane 3 no advance");
    a_lane2_sat: assert property ((wr42 || sn) && !clr && b[3:0] == 4'he
        && lane2_ffe_level_o == cap |=> $stable(lane2_ffe_level_o))
        else $error("lane 2 passed max");
    a_level_hold: assert property (!(wr42 || sn) |=> $stable(
        {lane2_ffe_level_o, lane3_ffe_level_o})) else $error("level moved");
    a_unmapped_zero: assert property (ce_i && reg_rd_i
        && !(reg_addr_i inside {8'h42, 8'h50, 8'h51}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_req_readback: assert property (s_wr_rd |=> reg_rdata_o
        == $past(reg_wdata_i, 2)) else $error("request readback wrong");
    a_done_clear: assert property (s_start ##1 (rd50 && !run_done_i)
        |=> !reg_rdata_o[7]) else $error("done not cleared");
    a_done_set: assert property (s_end ##1 (rd50 && !run_start_i)
        |=> reg_rdata_o[7]) else $error("done not set");
    a_code_report: assert property (s_end ##1 rd50
        |=> reg_rdata_o[3:0] == res_r[3:0]) else $error("eq code wrong");
    a_swing_eye: assert property (s_end ##1 rd51
        |=> reg_rdata_o == {1'b0, res_r[10:4]}) else $error("swing/eye wrong");
    a_done_valid: assert property (eq_done_valid_o == ((link_training_i
        && adaptive_eq_enable_i) || (forced_eq_run_enable_i
        && !forced_eq_run_i))) else $error("valid flag wrong");
endmodule : ltes_monitor
`default_nettype wire

// ==== verif/ltes_ddc_src.sv ====
// snooped ddc source: sends one byte strobe per request
// assumes the bench raises go_i for one cycle with the byte
`timescale 1ns/1ns
`default_nettype none
module ltes_ddc_src (
    input wire logic clk_i, // clock
    input wire logic go_i, // send request
    input wire logic [7:0] byte_i, // byte to send
    output logic vld_o, // snoop strobe
    output logic [7:0] data_o // snoop byte
);
    initial vld_o = 1'b0;
    initial data_o = 8'h00;
    // toggles between bytes so a stale byte never passes for a new one
    always @(posedge clk_i) begin
        vld_o <= go_i;
        data_o <= go_i ? byte_i : ~data_o;
    end
endmodule : ltes_ddc_src
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for ltes_top with a snoop source model
// assumes the monitor and the source model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, go = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, gob = 8'h00;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, snoop_vld_i, hit_i = 1'b0;
    logic [7:0] reg_rdata_o, snoop_data_i;
    logic [3:0] max_tx_ffe_level_i = 4'h3, run_eq_code_i = 4'h0;
    logic [3:0] run_eye_i = 4'h0;
    logic adaptive_eq_enable_i = 1'b0, link_training_i = 1'b0;
    logic forced_eq_run_enable_i = 1'b0, forced_eq_run_i = 1'b0;
    logic full_aeq_mode_i = 1'b0, eq_override_sign_i = 1'b0;
    logic [2:0] eq_override_offset_i = 3'h0, run_swing_i = 3'h0;
    logic run_start_i = 1'b0, run_done_i = 1'b0, settle_expired_i = 1'b0;
    logic eq_done_valid_o;
    logic [1:0] lane2_ffe_level_o, lane3_ffe_level_o;
    logic [7:0] pat [5] = '{8'he0, 8'h0e, 8'hee, 8'h5e, 8'hf0};
    int miscompares = 0, total_checks = 0, c, cap;
    int m_l2 = 0, m_l3 = 0, m_req = 0, m_done = 1, m_ovf = 0, m_set = 0;
    int m_code = 0, m_r51 = 0;
    always #5 clk_i = ~clk_i;
    ltes_top uut (.*);
    ltes_ddc_src src (.clk_i(clk_i), .go_i(go), .byte_i(gob),
        .vld_o(snoop_vld_i), .data_o(snoop_data_i));
    function automatic logic [7:0] r50();
        return 8'(m_done * 128 + m_ovf * 64 + m_set * 16 + m_code);
    endfunction : r50
    task automatic chk(input string n, input logic [7:0] e, s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic req(input logic [7:0] d);
        cap = max_tx_ffe_level_i > 4'h3 ? 3 : int'(max_tx_ffe_level_i);
        m_req = d;
        if (d[7:4] == 4'hf || d[3:0] == 4'hf) begin
            m_l2 = 0;
            m_l3 = 0;
        end else begin
            if (d[7:4] == 4'he && m_l3 < cap) m_l3++;
            if (d[3:0] == 4'he && m_l2 < cap) m_l2++;
        end
    endtask : req
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        if (a == 8'h42) req(d);
    endtask : wr
    task automatic snoop(input logic [7:0] d);
        @(posedge clk_i);
        go <= 1'b1;
        gob <= d;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        req(d);
    endtask : snoop
    task automatic rd_now(input logic [7:0] a, e);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("rdata", e, reg_rdata_o);
    endtask : rd_now
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_i);
        rd_now(a, e);
    endtask : rd
    task automatic final_report();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #500000 miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(32'h77c36a77));
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0; // enable stays high from power-up
        rd(8'h42, 8'h00);
        chk("levels", 8'h00,
            {4'h0, lane2_ffe_level_o, lane3_ffe_level_o});
        rd(8'h50, 8'h80);
        rd(8'h51, 8'h00);
        rd(8'h7f, 8'h00);
        wr(8'h50, 8'h3c);
        rd(8'h50, 8'h80);
        $display("test reset and access done");
        for (c = 0; c < 5; c++) begin
            wr(8'h42, 8'hff);
            max_tx_ffe_level_i <= 4'(c);
            repeat (8) begin
                if ($urandom_range(1)) wr(8'h42, pat[$urandom_range(4)]);
                else snoop(pat[$urandom_range(4)]);
                rd_now(8'h42, 8'(m_req));
                chk("levels", 8'(m_l2 * 4 + m_l3), {4'h0,
                    lane2_ffe_level_o, lane3_ffe_level_o});
            end
        end
        $display("test max_tx_ffe_level done");
        // a clearing write with the enable low must change nothing
        wr(8'h42, 8'hee);
        @(posedge clk_i);
        ce_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_wdata_i <= 8'hff;
        @(posedge clk_i);
        ce_i <= 1'b1;
        reg_wr_i <= 1'b0;
        rd_now(8'h42, 8'(m_req));
        chk("levels", 8'(m_l2 * 4 + m_l3), {4'h0,
            lane2_ffe_level_o, lane3_ffe_level_o});
        $display("test clock enable done");
        for (c = 0; c < 4; c++) begin
            @(posedge clk_i);
            link_training_i <= 1'($urandom);
            adaptive_eq_enable_i <= 1'($urandom);
            forced_eq_run_enable_i <= 1'($urandom);
            forced_eq_run_i <= 1'($urandom);
            run_start_i <= 1'b1;
            @(posedge clk_i);
            run_start_i <= 1'b0;
            m_done = 0;
            rd_now(8'h50, r50());
            chk("valid", 8'((link_training_i && adaptive_eq_enable_i) ||
                (forced_eq_run_enable_i && !forced_eq_run_i)),
                8'(eq_done_valid_o));
            if (c == 0) begin
                @(posedge clk_i);
                hit_i <= 1'b1;
                repeat (8191) @(posedge clk_i);
                hit_i <= 1'b0;
                rd(8'h50, r50());
                @(posedge clk_i);
                hit_i <= 1'b1;
                settle_expired_i <= 1'b1;
                @(posedge clk_i);
                hit_i <= 1'b0;
                settle_expired_i <= 1'b0;
                m_ovf = 1;
                m_set = 1;
                rd(8'h50, r50());
            end
            @(posedge clk_i);
            run_eq_code_i <= 4'($urandom);
            run_swing_i <= 3'($urandom);
            run_eye_i <= 4'($urandom);
            full_aeq_mode_i <= c[0];
            eq_override_sign_i <= 1'($urandom);
            eq_override_offset_i <= 3'($urandom);
            run_done_i <= 1'b1;
            @(posedge clk_i);
            run_done_i <= 1'b0;
            m_done = 1;
            m_code = (int'(run_eq_code_i) + (full_aeq_mode_i ? int'(
                {eq_override_sign_i, eq_override_offset_i}) : 0)) % 16;
            m_r51 = int'(run_swing_i) * 16 + int'(run_eye_i);
            if (c[1]) rd_now(8'h51, 8'(m_r51));
            else rd_now(8'h50, r50());
            rd(8'h50, r50());
            rd(8'h51, 8'(m_r51));
        end
        $display("test equalizer runs done");
        final_report();
    end
endmodule : tb
bind ltes_top ltes_monitor mon (.*);
`default_nettype wire
